// >>> dv/scor_regs_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker.
module scor_regs_asserts
   import scor_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire scor_req_type req_in,
   input wire logic enter_rx_in,
   input wire logic tx_calibrate_strobe_in,
   input wire logic tuning_node_test_input_in,
   input wire logic cal_active_out,
   input wire logic settle_extend_out,
   input wire logic long_measurement_out,
   input wire logic [4:0] tuning_array_out,
   input wire logic [5:0] current_a_out,
   input wire logic [5:0] current_b_out,
   input wire logic open_loop_out,
   input wire logic tuning_node_from_pin_out,
   input wire logic [3:0] pump_current_out,
   input wire logic pump_mask_out,
   input wire logic pump_force_up_out,
   input wire logic pump_force_down_out,
   input wire logic phase_det_long_delay_out
);
   logic [2:0] quiet_reg;
   wire tune_wr = req_in.wr && req_in.addr == ADDR_TUNING_ARRAY;
   wire time_wr = req_in.wr && req_in.addr == ADDR_CAL_TIMING;
   wire pump_wr = req_in.wr && req_in.addr == ADDR_PUMP;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // Cycles since the last write or calibration cycle.
   always_ff @(posedge clk_in) begin
      if (!resetn_in || req_in.wr || cal_active_out)
         quiet_reg <= 3'h0;
      else if (quiet_reg != 3'h7)
         quiet_reg <= quiet_reg + 3'h1;
   end
   rx_cal_a: assert property (enter_rx_in |=> cal_active_out)
      else $error("no calibration after receive entry");
   strobe_cal_a: assert property (tx_calibrate_strobe_in |=> cal_active_out)
      else $error("no calibration after strobe");
   settle_copy_a: assert property (tune_wr ##1 !tune_wr |=>
      settle_extend_out == $past(req_in.wdata[11], 2))
      else $error("settle extend wrong");
   long_copy_a: assert property (time_wr ##1 !time_wr |=>
      long_measurement_out == $past(req_in.wdata[14], 2))
      else $error("long measurement wrong");
   delay_copy_a: assert property (pump_wr ##1 !pump_wr |=>
      phase_det_long_delay_out == $past(req_in.wdata[10], 2))
      else $error("phase delay wrong");
   force_copy_a: assert property (pump_wr ##1 !pump_wr |=>
      {pump_force_up_out, pump_force_down_out} ==
      $past(req_in.wdata[13:12], 2))
      else $error("pump force wrong");
   mask_on_a: assert property (pump_wr && req_in.wdata[11] ##1 !pump_wr
      |=> pump_mask_out)
      else $error("pump not masked");
   test_pin_a: assert property (tuning_node_test_input_in[*2] |=>
      !open_loop_out && tuning_node_from_pin_out)
      else $error("test input ignored");
   results_hold_a: assert property (quiet_reg >= 3'h3 |->
      $stable(tuning_array_out) && $stable({current_a_out, current_b_out}))
      else $error("results moved between calibrations");
   step_down_a: assert property (quiet_reg >= 3'h3 &&
      $changed(pump_current_out) |->
      pump_current_out == $past(pump_current_out) - 4'h1)
      else $error("pump step not one code down");
endmodule : scor_regs_asserts

bind scor_regs scor_regs_asserts u_scor_regs_asserts (
   .clk_in(clk_in), .resetn_in(resetn_in), .req_in(req_in),
   .enter_rx_in(enter_rx_in),
   .tx_calibrate_strobe_in(tx_calibrate_strobe_in),
   .tuning_node_test_input_in(tuning_node_test_input_in),
   .cal_active_out(cal_active_out), .settle_extend_out(settle_extend_out),
   .long_measurement_out(long_measurement_out),
   .tuning_array_out(tuning_array_out), .current_a_out(current_a_out),
   .current_b_out(current_b_out), .open_loop_out(open_loop_out),
   .tuning_node_from_pin_out(tuning_node_from_pin_out),
   .pump_current_out(pump_current_out), .pump_mask_out(pump_mask_out),
   .pump_force_up_out(pump_force_up_out),
   .pump_force_down_out(pump_force_down_out),
   .phase_det_long_delay_out(phase_det_long_delay_out));

// >>> dv/scor_regs_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Testbench top.
module scor_regs_tb_top
   import scor_pkg::*;
;
   typedef struct packed {
      logic w;
      logic [5:0] a;
      logic [15:0] d;
      logic [15:0] e;
   } scor_row_type;
   localparam scor_row_type ROWS [10] = '{
      '{1'b0, ADDR_TUNING_ARRAY, 16'h0000, 16'h0210},
      '{1'b0, ADDR_CAL_TIMING, 16'h0000, 16'h5002},
      '{1'b0, ADDR_OSC_CURRENT, 16'h0000, 16'h0620},
      '{1'b0, ADDR_PUMP, 16'h0000, 16'h82DD},
      '{1'b0, 6'h26, 16'h0000, 16'h0000},
      '{1'b1, ADDR_TUNING_ARRAY, 16'h0FFF, 16'h0FF0},
      '{1'b1, ADDR_CAL_TIMING, 16'hA5AD, 16'hA5AD},
      '{1'b1, ADDR_OSC_CURRENT, 16'h7FFF, 16'h7FE0},
      '{1'b1, ADDR_PUMP, 16'h5A3C, 16'h5A3C},
      '{1'b1, 6'h2B, 16'hFFFF, 16'h0000}};
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [2:0] trg = 3'h0;
   logic test_en = 1'b0;
   scor_req_type req = '0;
   logic [15:0] rdata_out, got;
   logic cal_active_out, settle_extend_out, long_measurement_out;
   logic open_loop_out, tuning_node_from_pin_out, pump_mask_out;
   logic pump_force_up_out, pump_force_down_out, phase_det_long_delay_out;
   logic [1:0] current_cal_speed_out;
   logic [2:0] tuning_dac_out;
   logic [3:0] current_reference_out, pump_current_out;
   logic [4:0] tuning_array_out;
   logic [5:0] current_a_out, current_b_out;
   int mismatches = 0;
   int tests_run = 0;
   int n;
   always #10 clk_in = ~clk_in;
   scor_regs u_scor_regs (.clk_in(clk_in), .resetn_in(resetn_in),
      .req_in(req), .enter_rx_in(trg[0]), .enter_tx_in(trg[1]),
      .tx_calibrate_strobe_in(trg[2]), .tuning_node_test_input_in(test_en),
      .cal_array_in(5'h07), .cal_current_in(6'h2B), .rdata_out(rdata_out),
      .cal_active_out(cal_active_out), .settle_extend_out(settle_extend_out),
      .long_measurement_out(long_measurement_out),
      .current_reference_out(current_reference_out),
      .current_cal_speed_out(current_cal_speed_out),
      .tuning_array_out(tuning_array_out), .current_a_out(current_a_out),
      .current_b_out(current_b_out), .open_loop_out(open_loop_out),
      .tuning_node_from_pin_out(tuning_node_from_pin_out),
      .tuning_dac_out(tuning_dac_out), .pump_current_out(pump_current_out),
      .pump_mask_out(pump_mask_out), .pump_force_up_out(pump_force_up_out),
      .pump_force_down_out(pump_force_down_out),
      .phase_det_long_delay_out(phase_det_long_delay_out));
   // ==========================================================
   // Tasks.
   task automatic chk(input string nm, input logic [15:0] ex,
                      input logic [15:0] gt);
      tests_run++;
      if (gt !== ex) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, ex, gt);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_in);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge clk_in);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a);
      @(posedge clk_in);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge clk_in);
      req.rd <= 1'b0;
      @(negedge clk_in);
      got = rdata_out;
   endtask : rd
   task automatic pulse(input int i);
      @(posedge clk_in);
      trg[i] <= 1'b1;
      @(posedge clk_in);
      trg <= 3'h0;
   endtask : pulse
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up
   task automatic waitcal();
      n = 0;
      for (int i = 0; i < 4000; i++) begin
         @(negedge clk_in);
         if (cal_active_out === 1'b1) begin
            n++;
            if (n == 5)
               chk("calmask", {15'h0, pump_mask_out}, 16'h0001);
         end else if (n > 0)
            return;
      end
      mismatches++;
      wrap_up();
   endtask : waitcal
   // ==========================================================
   // Sequence.
   initial begin
      repeat (12) @(posedge clk_in);
      resetn_in <= 1'b1;
      for (int k = 0; k < 10; k++) begin
         if (ROWS[k].w)
            wr(ROWS[k].a, ROWS[k].d);
         rd(ROWS[k].a);
         chk("read", ROWS[k].e, got);
      end
      $display("register table done");
      repeat (3) @(negedge clk_in);
      chk("osc", {1'b0, current_a_out, current_b_out, tuning_dac_out},
          16'h7ED5);
      chk("cfg", {tuning_array_out, current_reference_out,
          current_cal_speed_out, settle_extend_out, long_measurement_out,
          open_loop_out, tuning_node_from_pin_out, 1'b0}, 16'hFCF4);
      chk("pump", {8'h00, pump_current_out, pump_mask_out, pump_force_up_out,
          pump_force_down_out, phase_det_long_delay_out}, 16'h00CA);
      @(posedge clk_in);
      test_en <= 1'b1;
      repeat (3) @(negedge clk_in);
      chk("node", {14'h0, open_loop_out, tuning_node_from_pin_out},
          16'h0001);
      test_en <= 1'b0;
      $display("output fields done");
      pulse(1);
      repeat (3) @(negedge clk_in);
      chk("txskip", {15'h0, cal_active_out}, 16'h0000);
      pulse(2);
      waitcal();
      chk("short", n[15:0], 16'h073A);
      rd(ADDR_TUNING_ARRAY);
      chk("ares", got, 16'h0FE7);
      rd(ADDR_OSC_CURRENT);
      chk("cres", got, 16'h7FEB);
      $display("calibration results done");
      wr(ADDR_CAL_TIMING, 16'h4000);
      wr(ADDR_PUMP, 16'h8025);
      pulse(1);
      waitcal();
      chk("long", n[15:0], 16'h0B22);
      repeat (3) @(negedge clk_in);
      chk("ramp0", {12'h0, pump_current_out}, 16'h0005);
      repeat (17) @(negedge clk_in);
      chk("ramp1", {12'h0, pump_current_out}, 16'h0004);
      repeat (60) @(negedge clk_in);
      chk("ramp2", {12'h0, pump_current_out}, 16'h0002);
      pulse(0);
      waitcal();
      chk("rx", n[15:0], 16'h0B22);
      $display("ramp done");
      wrap_up();
   end
endmodule : scor_regs_tb_top

// >>> logic/scor_regs.sv
`timescale 1ns/1ps
//Contract
// - Settle-extend bit doubles oscillator settling time.
// - Array override enable applies override value.
// - Array result holds latest calibration, resets 16.
// - Skip bit limits calibration to receive/strobe.
// - Long measurement makes calibration 57 us.
// - Bits 13:10 set reference current.
// - Constant doubles as branch B override.
// - Bit 3 picks loop filter or DAC.
// - Bits 14:13 set current calibration speed.
// - Current override drives branch A.
// - Current result holds latest calibration, resets 32.
// - Pump held off during calibration when set.
// - Pump current from ramp or start field.
// - Test bits force pump up or down.
// - Mask bit blocks phase detector pulses.
// - Bit 10 selects long phase-detector delay.
// - Bits 9:8 choose pump step interval.
// - After calibration, ramp down from start while above stop.
// - Test input overrides tuning-node source choice.
module scor_regs
   import scor_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire scor_req_type req_in,
   input wire logic enter_rx_in,
   input wire logic enter_tx_in,
   input wire logic tx_calibrate_strobe_in,
   input wire logic tuning_node_test_input_in,
   input wire logic [4:0] cal_array_in,
   input wire logic [5:0] cal_current_in,
   output logic [15:0] rdata_out,
   output logic cal_active_out,
   output logic settle_extend_out,
   output logic long_measurement_out,
   output logic [3:0] current_reference_out,
   output logic [1:0] current_cal_speed_out,
   output logic [4:0] tuning_array_out,
   output logic [5:0] current_a_out,
   output logic [5:0] current_b_out,
   output logic open_loop_out,
   output logic tuning_node_from_pin_out,
   output logic [2:0] tuning_dac_out,
   output logic [3:0] pump_current_out,
   output logic pump_mask_out,
   output logic pump_force_up_out,
   output logic pump_force_down_out,
   output logic phase_det_long_delay_out
);

   // ==========================================================
   // Helpers.
   function automatic logic [7:0] step_cycles(input logic [1:0] sel);
      case (sel)
         2'h0: step_cycles = 8'(STEP0_CYC);
         2'h1: step_cycles = 8'(STEP1_CYC);
         2'h2: step_cycles = 8'(STEP2_CYC);
         default: step_cycles = 8'(STEP3_CYC);
      endcase
   endfunction : step_cycles

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] wd,
                                         input logic [15:0] mask);
      merge = (old & ~mask) | (wd & mask);
   endfunction : merge

   // ==========================================================
   // Registers.
   logic [15:0] ta_reg;
   logic [15:0] ct_reg;
   logic [15:0] oc_reg;
   logic [15:0] pc_reg;
   logic [4:0] array_res_reg;
   logic [5:0] current_res_reg;
   logic [11:0] cal_cnt_reg;
   logic [7:0] step_cnt_reg;
   logic [3:0] ramp_reg;
   scor_state_type state_reg;

   // ==========================================================
   // Decode.
   wire wr_ta = req_in.wr && req_in.addr == ADDR_TUNING_ARRAY;
   wire wr_ct = req_in.wr && req_in.addr == ADDR_CAL_TIMING;
   wire wr_oc = req_in.wr && req_in.addr == ADDR_OSC_CURRENT;
   wire wr_pc = req_in.wr && req_in.addr == ADDR_PUMP;
   // Reserved bits are masked off on write and read as zero.
   wire [15:0] ta_next = wr_ta ?
      merge(ta_reg, req_in.wdata, MASK_TUNING_ARRAY) : ta_reg;
   wire [15:0] ct_next = wr_ct ?
      merge(ct_reg, req_in.wdata, MASK_CAL_TIMING) : ct_reg;
   wire [15:0] oc_next = wr_oc ?
      merge(oc_reg, req_in.wdata, MASK_OSC_CURRENT) : oc_reg;
   wire [15:0] pc_next = wr_pc ?
      merge(pc_reg, req_in.wdata, MASK_PUMP) : pc_reg;

   wire [15:0] rd_next =
      req_in.addr == ADDR_TUNING_ARRAY ? {ta_reg[15:5], array_res_reg} :
      req_in.addr == ADDR_CAL_TIMING ? ct_reg :
      req_in.addr == ADDR_OSC_CURRENT ? {oc_reg[15:6], current_res_reg} :
      req_in.addr == ADDR_PUMP ? pc_reg : 16'h0000;

   // ==========================================================
   // Calibration sequencer.
   wire cal_start = enter_rx_in || tx_calibrate_strobe_in ||
      (enter_tx_in && !ct_reg[CT_SKIP_TX]);
   wire [11:0] cal_len = ct_reg[CT_LONG_MEAS] ?
      12'(CAL_LONG_CYC) : 12'(CAL_SHORT_CYC);
   wire cal_done = state_reg == ST_CAL && cal_cnt_reg == 12'h001;
   wire [3:0] init_cur = pc_reg[PC_INIT_LSB +: 4];
   wire [3:0] end_cur = pc_reg[PC_END_LSB +: 4];
   wire step_now = state_reg == ST_RAMP && step_cnt_reg == 8'h01;
   wire [7:0] step_len = step_cycles(pc_reg[PC_STEP_LSB +: 2]);

   scor_state_type state_next;
   logic [11:0] cal_cnt_next;
   logic [7:0] step_cnt_next;
   logic [3:0] ramp_next;
   always_comb begin
      state_next = state_reg;
      cal_cnt_next = cal_cnt_reg;
      step_cnt_next = step_cnt_reg;
      ramp_next = ramp_reg;
      case (state_reg)
         ST_CAL: begin
            cal_cnt_next = cal_cnt_reg - 12'h001;
            if (cal_done) begin
               state_next = ST_RAMP;
               ramp_next = init_cur;
               step_cnt_next = step_len;
            end
         end
         ST_RAMP: begin
            step_cnt_next = step_now ? step_len : step_cnt_reg - 8'h01;
            if (step_now && ramp_reg > end_cur) begin
               ramp_next = ramp_reg - 4'h1;
            end
         end
         default: begin
         end
      endcase
      if (cal_start) begin
         state_next = ST_CAL;
         cal_cnt_next = cal_len;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         ta_reg <= RST_TUNING_ARRAY;
         ct_reg <= RST_CAL_TIMING;
         oc_reg <= RST_OSC_CURRENT;
         pc_reg <= RST_PUMP;
         array_res_reg <= RST_ARRAY_RESULT;
         current_res_reg <= RST_CURRENT_RESULT;
         state_reg <= ST_IDLE;
         cal_cnt_reg <= 12'h000;
         step_cnt_reg <= 8'h00;
         ramp_reg <= 4'h0;
         rdata_out <= 16'h0000;
      end else begin
         ta_reg <= ta_next;
         ct_reg <= ct_next;
         oc_reg <= oc_next;
         pc_reg <= pc_next;
         if (cal_done) begin
            array_res_reg <= cal_array_in;
            current_res_reg <= cal_current_in;
         end
         state_reg <= state_next;
         cal_cnt_reg <= cal_cnt_next;
         step_cnt_reg <= step_cnt_next;
         ramp_reg <= ramp_next;
         if (req_in.rd) begin
            rdata_out <= rd_next;
         end
      end
   end

   // ==========================================================
   // Analog controls.
   wire cal_run = state_next == ST_CAL;
   wire [4:0] array_sel = ta_reg[TA_OVERRIDE_EN] ?
      ta_reg[TA_OVERRIDE_LSB +: 5] : array_res_reg;
   wire cur_oe = oc_reg[OC_OVERRIDE_EN];
   wire [5:0] cur_a = cur_oe ?
      oc_reg[OC_OVERRIDE_LSB +: 6] : current_res_reg;
   wire [5:0] cur_b = cur_oe ? ct_reg[CT_K_LSB +: 6] : current_res_reg;
   wire [3:0] pump_cur = pc_reg[PC_OVERRIDE_EN] ? init_cur : ramp_next;
   wire mask_now = pc_reg[PC_MASK] ||
      (pc_reg[PC_OFF_IN_CAL] && cal_run);
   wire open_loop = !tuning_node_test_input_in &&
      ct_reg[CT_OPEN_LOOP];

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cal_active_out <= 1'b0;
         settle_extend_out <= 1'b0;
         long_measurement_out <= 1'b1;
         current_reference_out <= 4'h4;
         current_cal_speed_out <= 2'h0;
         tuning_array_out <= RST_ARRAY_RESULT;
         current_a_out <= RST_CURRENT_RESULT;
         current_b_out <= RST_CURRENT_RESULT;
         open_loop_out <= 1'b0;
         tuning_node_from_pin_out <= 1'b0;
         tuning_dac_out <= 3'h2;
         pump_current_out <= 4'h0;
         pump_mask_out <= 1'b1;
         pump_force_up_out <= 1'b0;
         pump_force_down_out <= 1'b0;
         phase_det_long_delay_out <= 1'b0;
      end else begin
         cal_active_out <= cal_run;
         settle_extend_out <= ta_next[TA_SETTLE_EXTEND];
         long_measurement_out <= ct_next[CT_LONG_MEAS];
         current_reference_out <= ct_next[CT_REF_LSB +: 4];
         current_cal_speed_out <= oc_next[OC_SPEED_LSB +: 2];
         tuning_array_out <= array_sel;
         current_a_out <= cur_a;
         current_b_out <= cur_b;
         open_loop_out <= open_loop;
         tuning_node_from_pin_out <= tuning_node_test_input_in;
         tuning_dac_out <= ct_reg[CT_DAC_LSB +: 3];
         pump_current_out <= pump_cur;
         pump_mask_out <= mask_now;
         pump_force_up_out <= pc_reg[PC_FORCE_UP];
         pump_force_down_out <= pc_reg[PC_FORCE_DOWN];
         phase_det_long_delay_out <= pc_reg[PC_LONG_DELAY];
      end
   end

endmodule : scor_regs

// >>> pkg/scor_pkg.sv
package scor_pkg;

   // ==========================================================
   // Register port carrier.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [15:0] wdata;
   } scor_req_type;

   // ==========================================================
   // Register indices.
   localparam logic [5:0] ADDR_TUNING_ARRAY = 6'h27;
   localparam logic [5:0] ADDR_CAL_TIMING = 6'h28;
   localparam logic [5:0] ADDR_OSC_CURRENT = 6'h29;
   localparam logic [5:0] ADDR_PUMP = 6'h2A;

   // ==========================================================
   // Reset values and writable bit masks.
   localparam logic [15:0] RST_TUNING_ARRAY = 16'h0200;
   localparam logic [15:0] RST_CAL_TIMING = 16'h5002;
   localparam logic [15:0] RST_OSC_CURRENT = 16'h0600;
   localparam logic [15:0] RST_PUMP = 16'h82DD;
   localparam logic [4:0] RST_ARRAY_RESULT = 5'h10;
   localparam logic [5:0] RST_CURRENT_RESULT = 6'h20;
   localparam logic [15:0] MASK_TUNING_ARRAY = 16'h0FE0;
   localparam logic [15:0] MASK_CAL_TIMING = 16'hFFFF;
   localparam logic [15:0] MASK_OSC_CURRENT = 16'h7FC0;
   localparam logic [15:0] MASK_PUMP = 16'hFFFF;

   // ==========================================================
   // Field positions.
   localparam int TA_SETTLE_EXTEND = 11;
   localparam int TA_OVERRIDE_EN = 10;
   localparam int TA_OVERRIDE_LSB = 5;
   localparam int CT_SKIP_TX = 15;
   localparam int CT_LONG_MEAS = 14;
   localparam int CT_REF_LSB = 10;
   localparam int CT_K_LSB = 4;
   localparam int CT_OPEN_LOOP = 3;
   localparam int CT_DAC_LSB = 0;
   localparam int OC_SPEED_LSB = 13;
   localparam int OC_OVERRIDE_EN = 12;
   localparam int OC_OVERRIDE_LSB = 6;
   localparam int PC_OFF_IN_CAL = 15;
   localparam int PC_OVERRIDE_EN = 14;
   localparam int PC_FORCE_UP = 13;
   localparam int PC_FORCE_DOWN = 12;
   localparam int PC_MASK = 11;
   localparam int PC_LONG_DELAY = 10;
   localparam int PC_STEP_LSB = 8;
   localparam int PC_END_LSB = 4;
   localparam int PC_INIT_LSB = 0;

   // ==========================================================
   // Timing.
   localparam int CLK_MHZ = 50;
   localparam int CAL_SHORT_US = 37;
   localparam int CAL_LONG_US = 57;
   localparam int CAL_SHORT_CYC = CAL_SHORT_US * CLK_MHZ;
   localparam int CAL_LONG_CYC = CAL_LONG_US * CLK_MHZ;
   localparam int STEP0_NS = 250;
   localparam int STEP1_NS = 500;
   localparam int STEP2_NS = 1000;
   localparam int STEP3_NS = 4000;
   localparam int STEP0_CYC = (STEP0_NS * CLK_MHZ + 999) / 1000;
   localparam int STEP1_CYC = (STEP1_NS * CLK_MHZ + 999) / 1000;
   localparam int STEP2_CYC = (STEP2_NS * CLK_MHZ + 999) / 1000;
   localparam int STEP3_CYC = (STEP3_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CAL,
      ST_RAMP
   } scor_state_type;

endpackage : scor_pkg
